// ---- src/xsk_alu.sv ----
// Purpose: Result, destination, skip and flag logic for one instruction
// Assumes: Operand byte already read from data memory
// Notes: Purely combinational; the caller registers everything
`timescale 1ns/1ps
module xsk_alu
   import xsk_pkg::*;
(
   input wire xsk_instr_t instr,
   input wire logic [7:0] acc,
   input wire logic [7:0] mbyte,
   input wire xsk_flags_t flags_in,
   output xsk_alu_t out
);

   // Accumulator minus byte with full flag set
   function automatic xsk_flags_t sub_flags(input logic [7:0] a, input logic [7:0] m);
      logic [8:0] d;
      logic [4:0] dl;
      xsk_flags_t f;
      d = {1'b0, a} - {1'b0, m};
      dl = {1'b0, a[3:0]} - {1'b0, m[3:0]};
      f.carry_flag = ~d[8];
      f.aux_carry_flag = ~dl[4];
      f.zero_flag = (d[7:0] == 8'h00);
      f.overflow_flag = (a[7] ^ m[7]) & (a[7] ^ d[7]);
      f.signed_carry_flag = f.overflow_flag ^ d[7];
      f.chained_zero_flag = f.zero_flag;
      return f;
   endfunction

   logic [7:0] dec;
   logic [7:0] inc;
   logic [7:0] swp;
   logic [7:0] xr;

   assign dec = mbyte - 8'h01;
   assign inc = mbyte + 8'h01;
   assign swp = {mbyte[3:0], mbyte[7:4]};
   assign xr = acc ^ mbyte;

   // Decode of one operation
   always_comb begin
      out = '0;
      out.flags = flags_in;
      out.known = 1'b1;
      case (instr.op)
         XSK_DEC_SKIP_ZERO: begin
            out.res = dec;
            out.wr_mem = 1'b1;
            out.skip = (dec == 8'h00);
         end
         XSK_DEC_SKIP_ZERO_TO_ACC: begin
            out.res = dec;
            out.wr_acc = 1'b1;
            out.skip = (dec == 8'h00);
         end
         XSK_FILL_ONES: begin
            out.res = XSK_ONES;
            out.wr_mem = 1'b1;
         end
         XSK_SET_BIT: begin
            out.res = mbyte | (8'h01 << instr.bit_sel);
            out.wr_mem = 1'b1;
         end
         XSK_INC_SKIP_ZERO: begin
            out.res = inc;
            out.wr_mem = 1'b1;
            out.skip = (inc == 8'h00);
         end
         XSK_INC_SKIP_ZERO_TO_ACC: begin
            out.res = inc;
            out.wr_acc = 1'b1;
            out.skip = (inc == 8'h00);
         end
         XSK_SKIP_NONZERO: begin
            out.skip = (mbyte != 8'h00);
         end
         XSK_SUBTRACT_BYTE: begin
            out.res = acc - mbyte;
            out.wr_acc = 1'b1;
            out.wr_flags = 1'b1;
            out.flags = sub_flags(acc, mbyte);
         end
         XSK_SUBTRACT_BYTE_WRITEBACK: begin
            out.res = acc - mbyte;
            out.wr_mem = 1'b1;
            out.wr_flags = 1'b1;
            out.flags = sub_flags(acc, mbyte);
         end
         XSK_NIBBLE_EXCHANGE: begin
            out.res = swp;
            out.wr_mem = 1'b1;
         end
         XSK_NIBBLE_EXCHANGE_TO_ACC: begin
            out.res = swp;
            out.wr_acc = 1'b1;
         end
         XSK_SKIP_WHEN_ZERO: begin
            out.skip = (mbyte == 8'h00);
         end
         XSK_COPY_SKIP_WHEN_ZERO: begin
            out.res = mbyte;
            out.wr_acc = 1'b1;
            out.skip = (mbyte == 8'h00);
         end
         XSK_SKIP_BIT_CLEAR: begin
            out.skip = ~mbyte[instr.bit_sel];
         end
         XSK_EXCLUSIVE_OR_TO_ACC: begin
            out.res = xr;
            out.wr_acc = 1'b1;
            out.wr_flags = 1'b1;
            out.flags.zero_flag = (xr == 8'h00);
         end
         XSK_EXCLUSIVE_OR_TO_MEMORY: begin
            out.res = xr;
            out.wr_mem = 1'b1;
            out.wr_flags = 1'b1;
            out.flags.zero_flag = (xr == 8'h00);
         end
         XSK_TABLE_READ_CURRENT_PAGE, XSK_TABLE_READ_FINAL_PAGE,
         XSK_PREINC_TABLE_READ, XSK_PREINC_TABLE_READ_FINAL_PAGE: begin
            out.known = 1'b1; // Handled by the fetch states
         end
         default: begin
            out.known = 1'b0;
         end
      endcase
   end

endmodule

// ---- src/xsk_core.sv ----
// Purpose: Execute stage for extended skip, set, subtract, swap, xor and table reads
// Assumes: APB master on clk; program memory answers one cycle after prog_rd
// Notes: Software issues one instruction per write; busy stalls the bus
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module xsk_core
   import xsk_pkg::*;
#(
   parameter int PW = 13,
   parameter int DEPTH = 256
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [XSK_APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic prog_rd,
   output logic [PW-1:0] prog_addr,
   input wire logic [15:0] prog_data,
   output logic busy
);

   // ----------------------------------------
   // Types and state
   // ----------------------------------------
   typedef enum logic [5:0] {
      XSK_IDLE = 6'b000001,
      XSK_MREAD = 6'b000010,
      XSK_EXEC = 6'b000100,
      XSK_PFETCH = 6'b001000,
      XSK_PWAIT = 6'b010000,
      XSK_DUMMY = 6'b100000
   } xsk_state_t;

   localparam logic [PW-9:0] LAST_PAGE = '1;

   xsk_state_t state, next_state;
   xsk_instr_t ir, next_ir;
   xsk_flags_t flags, next_flags;
   logic [7:0] acc, next_acc;
   logic [7:0] ptr_lo, next_ptr_lo;
   logic [7:0] ptr_hi, next_ptr_hi;
   logic [7:0] tab_hi, next_tab_hi;
   logic [PW-9:0] page, next_page;
   logic skip_pend, next_skip_pend;
   logic last_skip, next_last_skip;
   logic bad_op, next_bad_op;
   logic [7:0] supp_cnt, next_supp_cnt;
   logic [1:0] ack, next_ack;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic next_prog_rd;
   logic [PW-1:0] next_prog_addr;
   logic next_busy;

   logic mem_we;
   logic [7:0] mem_addr;
   logic [7:0] mem_wd;
   logic [7:0] mem_q;
   xsk_alu_t alu;

   logic acc_phase;
   logic done;
   logic wr_done;
   logic in_mem;
   logic mapped;
   logic is_table;

   // Decode helper: register offset match on the word address
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return (a[11:2] == off[11:2]);
   endfunction

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   xsk_dmem #(
      .DEPTH(DEPTH),
      .AW(8)
   ) u_dmem (
      .clk(clk),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wd),
      .q(mem_q)
   );

   xsk_alu u_alu (
      .instr(ir),
      .acc(acc),
      .mbyte(mem_q),
      .flags_in(flags),
      .out(alu)
   );

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // Bus only served while idle; that is the back-pressure on instruction issue
   assign acc_phase = psel && penable && (state == XSK_IDLE);
   assign done = psel && penable && pready;
   assign wr_done = done && pwrite && pstrb[0];
   assign in_mem = (paddr[11:10] == XSK_MEM_SEL);
   assign is_table = (ir.op == XSK_TABLE_READ_CURRENT_PAGE)
      || (ir.op == XSK_TABLE_READ_FINAL_PAGE)
      || (ir.op == XSK_PREINC_TABLE_READ)
      || (ir.op == XSK_PREINC_TABLE_READ_FINAL_PAGE);

   // Address map check, unmapped offsets answer with an error
   always_comb begin
      if (in_mem) begin
         mapped = 1'b1;
      end else if (hit(paddr, XSK_OFF_INSTR) || hit(paddr, XSK_OFF_ACC)) begin
         mapped = 1'b1;
      end else if (hit(paddr, XSK_OFF_FLAGS) || hit(paddr, XSK_OFF_PTR_LO)) begin
         mapped = 1'b1;
      end else if (hit(paddr, XSK_OFF_PTR_HI) || hit(paddr, XSK_OFF_TAB_HI)) begin
         mapped = 1'b1;
      end else if (hit(paddr, XSK_OFF_STATE) || hit(paddr, XSK_OFF_PAGE)) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   // ----------------------------------------
   // Data memory port sharing
   // ----------------------------------------
   // Core owns the port while busy, the bus window only while idle
   always_comb begin
      mem_we = 1'b0;
      mem_addr = ir.addr;
      mem_wd = alu.res;
      if (state == XSK_IDLE) begin
         mem_addr = paddr[9:2];
         mem_wd = pwdata[7:0];
         mem_we = wr_done && in_mem && !pslverr;
      end else if (state == XSK_EXEC) begin
         mem_we = alu.wr_mem;
      end else if (state == XSK_PWAIT) begin
         mem_wd = prog_data[7:0];
         mem_we = 1'b1;
      end
   end

   // ----------------------------------------
   // Bus answer sequencing
   // ----------------------------------------
   // Three-step answer: issue read, capture data, hold pready one cycle
   always_comb begin
      next_ack = ack;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = prdata;
      if (done) begin
         next_ack = XSK_ACK_ISSUE;
      end else if (acc_phase && ack == XSK_ACK_ISSUE) begin
         next_ack = XSK_ACK_DATA;
      end else if (acc_phase && ack == XSK_ACK_DATA) begin
         next_ack = XSK_ACK_DONE;
         next_pready = 1'b1;
         next_pslverr = !mapped;
         next_prdata = 32'h0000_0000;
         if (!pwrite) begin
            if (in_mem) begin
               next_prdata[7:0] = mem_q;
            end else if (hit(paddr, XSK_OFF_ACC)) begin
               next_prdata[7:0] = acc;
            end else if (hit(paddr, XSK_OFF_FLAGS)) begin
               next_prdata[XSK_FLAGS_W-1:0] = flags;
            end else if (hit(paddr, XSK_OFF_PTR_LO)) begin
               next_prdata[7:0] = ptr_lo;
            end else if (hit(paddr, XSK_OFF_PTR_HI)) begin
               next_prdata[7:0] = ptr_hi;
            end else if (hit(paddr, XSK_OFF_TAB_HI)) begin
               next_prdata[7:0] = tab_hi;
            end else if (hit(paddr, XSK_OFF_PAGE)) begin
               next_prdata[PW-9:0] = page;
            end else if (hit(paddr, XSK_OFF_STATE)) begin
               next_prdata[XSK_ST_SKIP_PEND] = skip_pend;
               next_prdata[XSK_ST_LAST_SKIP] = last_skip;
               next_prdata[XSK_ST_BAD_OP] = bad_op;
               next_prdata[XSK_ST_SUPP_LSB +: 8] = supp_cnt;
            end else begin
               next_prdata[XSK_INSTR_W-1:0] = ir;
            end
         end
      end
   end

   // ----------------------------------------
   // Execute sequencer
   // ----------------------------------------
   // Next state, architectural registers and program fetch
   always_comb begin
      next_state = state;
      next_ir = ir;
      next_flags = flags;
      next_acc = acc;
      next_ptr_lo = ptr_lo;
      next_ptr_hi = ptr_hi;
      next_tab_hi = tab_hi;
      next_page = page;
      next_skip_pend = skip_pend;
      next_last_skip = last_skip;
      next_bad_op = bad_op;
      next_supp_cnt = supp_cnt;
      next_prog_rd = 1'b0;
      next_prog_addr = prog_addr;
      case (state)
         XSK_IDLE: begin
            if (wr_done && !in_mem && !pslverr) begin
               if (hit(paddr, XSK_OFF_INSTR)) begin
                  next_ir = pwdata[XSK_INSTR_W-1:0];
                  if (skip_pend) begin
                     // Fetched but not executed: no write of any kind
                     next_skip_pend = 1'b0;
                     next_supp_cnt = supp_cnt + 8'h01;
                     next_state = XSK_DUMMY;
                  end else begin
                     next_state = XSK_MREAD;
                  end
               end else if (hit(paddr, XSK_OFF_ACC)) begin
                  next_acc = pwdata[7:0];
               end else if (hit(paddr, XSK_OFF_FLAGS)) begin
                  next_flags = pwdata[XSK_FLAGS_W-1:0];
               end else if (hit(paddr, XSK_OFF_PTR_LO)) begin
                  next_ptr_lo = pwdata[7:0];
               end else if (hit(paddr, XSK_OFF_PTR_HI)) begin
                  next_ptr_hi = pwdata[7:0];
               end else if (hit(paddr, XSK_OFF_PAGE)) begin
                  next_page = pwdata[PW-9:0];
               end
            end
         end
         XSK_MREAD: begin
            if (is_table) begin
               next_state = XSK_PFETCH;
               next_prog_rd = 1'b1;
               case (ir.op)
                  XSK_TABLE_READ_CURRENT_PAGE: begin
                     next_prog_addr = {page, ptr_lo};
                  end
                  XSK_TABLE_READ_FINAL_PAGE: begin
                     next_prog_addr = {LAST_PAGE, ptr_lo};
                  end
                  XSK_PREINC_TABLE_READ: begin
                     next_ptr_lo = ptr_lo + 8'h01;
                     next_prog_addr = {ptr_hi[PW-9:0], next_ptr_lo};
                  end
                  default: begin
                     next_ptr_lo = ptr_lo + 8'h01;
                     next_prog_addr = {LAST_PAGE, next_ptr_lo};
                  end
               endcase
            end else begin
               next_state = XSK_EXEC;
            end
         end
         XSK_EXEC: begin
            if (alu.wr_acc) begin
               next_acc = alu.res;
            end
            if (alu.wr_flags) begin
               next_flags = alu.flags;
            end
            next_bad_op = !alu.known;
            next_last_skip = alu.skip;
            if (alu.skip) begin
               next_skip_pend = 1'b1;
               next_state = XSK_DUMMY;
            end else begin
               next_state = XSK_IDLE;
            end
         end
         XSK_PFETCH: begin
            next_state = XSK_PWAIT;
         end
         XSK_PWAIT: begin
            next_tab_hi = prog_data[15:8];
            next_last_skip = 1'b0;
            next_bad_op = 1'b0;
            next_state = XSK_IDLE;
         end
         XSK_DUMMY: begin
            next_state = XSK_IDLE;
         end
         default: begin
            next_state = XSK_IDLE;
         end
      endcase
      next_busy = (next_state != XSK_IDLE);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Every output leaves a flip-flop
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= XSK_IDLE;
         ir <= '0;
         flags <= '0;
         acc <= XSK_BYTE_RST;
         ptr_lo <= XSK_BYTE_RST;
         ptr_hi <= XSK_BYTE_RST;
         tab_hi <= XSK_BYTE_RST;
         page <= '0;
         skip_pend <= 1'b0;
         last_skip <= 1'b0;
         bad_op <= 1'b0;
         supp_cnt <= XSK_BYTE_RST;
         ack <= XSK_ACK_ISSUE;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prog_rd <= 1'b0;
         prog_addr <= '0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         ir <= next_ir;
         flags <= next_flags;
         acc <= next_acc;
         ptr_lo <= next_ptr_lo;
         ptr_hi <= next_ptr_hi;
         tab_hi <= next_tab_hi;
         page <= next_page;
         skip_pend <= next_skip_pend;
         last_skip <= next_last_skip;
         bad_op <= next_bad_op;
         supp_cnt <= next_supp_cnt;
         ack <= next_ack;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         prog_rd <= next_prog_rd;
         prog_addr <= next_prog_addr;
         busy <= next_busy;
      end
   end

endmodule

// ---- src/xsk_dmem.sv ----
// Purpose: Single-port data memory with registered read data
// Assumes: One access per cycle, a read during a write returns the old contents
// Notes: Contents are not reset, as in a real RAM
`timescale 1ns/1ps
module xsk_dmem #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] q
);

   logic [7:0] mem [DEPTH];

   // Write port and registered read
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      q <= mem[addr];
   end

endmodule

// ---- src/xsk_pkg.sv ----
// Purpose: Shared constants and types for the extended skip/table execute block
// Assumes: 32-bit APB data, 8-bit data memory, 16-bit program words
// Notes: Register map is word aligned; data memory window sits at its own base
package xsk_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam int XSK_APB_AW = 12;
   localparam logic [11:0] XSK_OFF_INSTR = 12'h000;
   localparam logic [11:0] XSK_OFF_ACC = 12'h004;
   localparam logic [11:0] XSK_OFF_FLAGS = 12'h008;
   localparam logic [11:0] XSK_OFF_PTR_LO = 12'h00c;
   localparam logic [11:0] XSK_OFF_PTR_HI = 12'h010;
   localparam logic [11:0] XSK_OFF_TAB_HI = 12'h014;
   localparam logic [11:0] XSK_OFF_STATE = 12'h018;
   localparam logic [11:0] XSK_OFF_PAGE = 12'h01c;
   localparam logic [1:0] XSK_MEM_SEL = 2'h1; // paddr[11:10]: data memory window

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int XSK_INSTR_W = 16; // op [4:0], addr [12:5], bit [15:13]
   localparam int XSK_FLAGS_W = 6; // Carry at bit 0, chained zero at bit 5
   localparam int XSK_ST_BUSY = 0;
   localparam int XSK_ST_SKIP_PEND = 1;
   localparam int XSK_ST_LAST_SKIP = 2;
   localparam int XSK_ST_BAD_OP = 3;
   localparam int XSK_ST_SUPP_LSB = 8; // 8-bit count of suppressed instructions
   localparam logic [7:0] XSK_BYTE_RST = 8'h00;
   localparam logic [7:0] XSK_ONES = 8'hff;
   localparam logic [1:0] XSK_ACK_ISSUE = 2'h0;
   localparam logic [1:0] XSK_ACK_DATA = 2'h1;
   localparam logic [1:0] XSK_ACK_DONE = 2'h2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [4:0] {
      XSK_DEC_SKIP_ZERO = 5'h00,
      XSK_DEC_SKIP_ZERO_TO_ACC = 5'h01,
      XSK_FILL_ONES = 5'h02,
      XSK_SET_BIT = 5'h03,
      XSK_INC_SKIP_ZERO = 5'h04,
      XSK_INC_SKIP_ZERO_TO_ACC = 5'h05,
      XSK_SKIP_NONZERO = 5'h06,
      XSK_SUBTRACT_BYTE = 5'h07,
      XSK_SUBTRACT_BYTE_WRITEBACK = 5'h08,
      XSK_NIBBLE_EXCHANGE = 5'h09,
      XSK_NIBBLE_EXCHANGE_TO_ACC = 5'h0a,
      XSK_SKIP_WHEN_ZERO = 5'h0b,
      XSK_COPY_SKIP_WHEN_ZERO = 5'h0c,
      XSK_SKIP_BIT_CLEAR = 5'h0d,
      XSK_TABLE_READ_CURRENT_PAGE = 5'h0e,
      XSK_TABLE_READ_FINAL_PAGE = 5'h0f,
      XSK_PREINC_TABLE_READ = 5'h10,
      XSK_PREINC_TABLE_READ_FINAL_PAGE = 5'h11,
      XSK_EXCLUSIVE_OR_TO_ACC = 5'h12,
      XSK_EXCLUSIVE_OR_TO_MEMORY = 5'h13
   } xsk_op_t;

   typedef struct packed {
      logic chained_zero_flag;
      logic signed_carry_flag;
      logic overflow_flag;
      logic zero_flag;
      logic aux_carry_flag;
      logic carry_flag;
   } xsk_flags_t;

   typedef struct packed {
      logic [2:0] bit_sel;
      logic [7:0] addr;
      xsk_op_t op;
   } xsk_instr_t;

   typedef struct packed {
      logic [7:0] res;
      logic wr_acc;
      logic wr_mem;
      logic wr_flags;
      logic skip;
      logic known;
      xsk_flags_t flags;
   } xsk_alu_t;

endpackage

// ---- tb/xsk_core_props.sv ----
// Purpose: Port-level checks on the execute block
// Assumes: Single clock domain, async active-low reset
// Notes: Bound into every instance of the core
`timescale 1ns/1ps
module xsk_core_props
   import xsk_pkg::*;
#(
   parameter int PW = 13
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [XSK_APB_AW-1:0] paddr,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic prog_rd,
   input wire logic [PW-1:0] prog_addr,
   input wire logic busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Completed instruction write, the cause of every execution
   wire iwr = psel && penable && pready && pwrite && !pslverr && pstrb[0] && paddr == XSK_OFF_INSTR;
   chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   chk_err_pair: assert property (pslverr |-> pready) else $error("pslverr alone");
   chk_ready_cause: assert property (pready |-> psel && penable) else $error("stray pready");
   chk_instr_busy: assert property (iwr |=> busy) else $error("no busy");
   chk_busy_len: assert property ($rose(busy) |-> ##[1:3] !busy) else $error("busy length");
   chk_busy_stall: assert property (busy |-> !pready) else $error("answer while busy");
   chk_fetch_pulse: assert property (prog_rd |=> !prog_rd && $stable(prog_addr))
      else $error("fetch pulse");
   chk_fetch_end: assert property (prog_rd |-> busy ##1 busy ##1 !busy)
      else $error("fetch timing");
   chk_fetch_after: assert property (prog_rd |-> $past(busy)) else $error("fetch cause");
endmodule
bind xsk_core xsk_core_props #(.PW(PW)) u_props (.clk(clk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pready(pready),
   .pslverr(pslverr), .prog_rd(prog_rd), .prog_addr(prog_addr), .busy(busy));

// ---- tb/xsk_core_tb.sv ----
// Purpose: Self-checking bench for the execute block
// Assumes: Program memory model on the far side
// Notes: Expected values come from a local reference of each opcode
`timescale 1ns/1ps
module xsk_core_tb;
   import xsk_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, prog_rd, busy;
   logic [12:0] prog_addr;
   logic [15:0] prog_data;
   logic [33:0] expq[$];
   logic [7:0] tbh = 8'h00;
   logic [7:0] n_supp = 8'h00;
   int n_errors = 0, num_checks = 0;
   always #10 clk = ~clk;
   xsk_core u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_data(prog_data),
      .busy(busy));
   xsk_pmem_model u_pm (.clk(clk), .prog_rd(prog_rd), .prog_addr(prog_addr),
      .prog_data(prog_data));
   task automatic results();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One APB transfer; its expected answer is noted first
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [33:0] e);
      int k;
      expq.push_back(e);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      psel <= 0;
      penable <= 0;
      if (k >= 50) begin
         n_errors++;
         results();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1, a, {24'h0, d}, 34'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d);
      apb(0, a, 32'h0, {2'b10, d});
   endtask
   // Take the oldest note off the queue at every answer
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         logic [33:0] e;
         e = expq.pop_front();
         num_checks++;
         if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
            $display("[ERR] %0t answer mismatch at %h", $time, paddr);
            n_errors++;
         end
      end
   end
   function automatic logic [7:0] pick();
      logic [1:0] s;
      s = $urandom;
      return s == 0 ? 8'h00 : s == 1 ? 8'h01 : s == 2 ? 8'hff : 8'($urandom);
   endfunction
   // Run one instruction from random state, then a probe that a skip must suppress
   task automatic exec(input logic [4:0] op);
      logic [7:0] m, mv, av, tl, th, pg, nm, na, r;
      logic [2:0] b;
      logic [12:0] pa;
      logic sk;
      xsk_flags_t f, nf;
      m = $urandom;
      mv = pick();
      av = pick();
      tl = pick();
      th = $urandom;
      pg = $urandom;
      b = $urandom;
      f = $urandom;
      wr({2'h1, m, 2'h0}, mv);
      wr({2'h1, m ^ 8'h01, 2'h0}, 8'h00);
      wr(XSK_OFF_ACC, av);
      wr(XSK_OFF_FLAGS, {2'h0, f});
      wr(XSK_OFF_PTR_LO, tl);
      wr(XSK_OFF_PTR_HI, th);
      wr(XSK_OFF_PAGE, {3'h0, pg[4:0]});
      nm = mv;
      na = av;
      nf = f;
      sk = 0;
      r = av - mv;
      case (op)
         5'h00, 5'h01: r = mv - 8'h01;
         5'h04, 5'h05: r = mv + 8'h01;
         5'h09, 5'h0a: r = {mv[3:0], mv[7:4]};
         5'h12, 5'h13: r = av ^ mv;
         default: ;
      endcase
      case (op)
         5'h00, 5'h04, 5'h08, 5'h09, 5'h13: nm = r;
         5'h01, 5'h05, 5'h07, 5'h0a, 5'h12: na = r;
         5'h02: nm = 8'hff;
         5'h03: nm = mv | (8'h01 << b);
         5'h0c: na = mv;
         default: ;
      endcase
      case (op)
         5'h00, 5'h01, 5'h04, 5'h05: sk = r == 0;
         5'h06: sk = mv != 0;
         5'h0b, 5'h0c: sk = mv == 0;
         5'h0d: sk = !mv[b];
         5'h07, 5'h08: nf = {r == 0, ((av[7] ^ mv[7]) & (r[7] ^ av[7])) ^ r[7],
            (av[7] ^ mv[7]) & (r[7] ^ av[7]), r == 0, av[3:0] >= mv[3:0], av >= mv};
         5'h12, 5'h13: nf.zero_flag = r == 0;
         default: ;
      endcase
      if (op >= 5'h0e && op <= 5'h11) begin
         if (op[4]) tl++;
         pa = {op[0] ? 5'h1f : op[4] ? th[4:0] : pg[4:0], tl};
         nm = pa[7:0];
         tbh = pa[12:5] ^ 8'ha5;
      end
      apb(1, XSK_OFF_INSTR, {16'h0, b, m, op}, 34'h0);
      apb(1, XSK_OFF_INSTR, {19'h0, m ^ 8'h01, XSK_FILL_ONES}, 34'h0);
      // A taken skip suppresses the probe and counts it
      n_supp = n_supp + 8'(sk);
      rd(XSK_OFF_ACC, {24'h0, na});
      rd({2'h1, m, 2'h0}, {24'h0, nm});
      rd(XSK_OFF_FLAGS, {26'h0, nf});
      rd(XSK_OFF_TAB_HI, {24'h0, tbh});
      rd(XSK_OFF_PTR_LO, {24'h0, tl});
      rd({2'h1, m ^ 8'h01, 2'h0}, sk ? 32'h0 : 32'hff);
      rd(XSK_OFF_STATE, {16'h0, n_supp, 5'h0, sk, 2'h0});
   endtask
   initial begin
      void'($urandom(50360));
      repeat (20) @(posedge clk);
      rstn <= 1;
      rd(XSK_OFF_ACC, 32'h0);
      // A write without its low strobe completes but changes nothing
      pstrb <= 4'he;
      wr(XSK_OFF_ACC, 8'h5a);
      pstrb <= 4'hf;
      rd(XSK_OFF_ACC, 32'h0);
      apb(0, 12'h020, 32'h0, {2'b01, 32'h0});
      repeat (6) begin
         for (int i = 0; i < 20; i++) exec(i[4:0]);
      end
      results();
   end
endmodule

// ---- tb/xsk_pmem_model.sv ----
// Purpose: Program memory seen from the execute block
// Assumes: Fixed one-cycle read latency after prog_rd
// Notes: Word content is a fixed pattern of its address
`timescale 1ns/1ps
module xsk_pmem_model (
   input wire logic clk,
   input wire logic prog_rd,
   input wire logic [12:0] prog_addr,
   output logic [15:0] prog_data
);
   logic valid = 1'b0;
   logic [15:0] word = 16'h0000;
   // Capture the request; the answer stands in the following cycle only
   always @(posedge clk) begin
      valid <= prog_rd;
      if (prog_rd) word <= {prog_addr[12:5] ^ 8'ha5, prog_addr[7:0]};
   end
   // Outside the answer cycle show the inverse, so stale data never passes
   assign prog_data = valid ? word : ~word;
endmodule
